// ==== ssrp_read_port.v ====
// read port of a burst synchronous sram: select, latency, ddr bursts, valid flag, echo clocks
`include "ssrp_consts.vh"

module ssrp_read_port (
   // system clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // input clock pair from the host
   input wire k_i,
   input wire k_n_i,
   // read request from the host
   input wire read_port_select_n_i,
   input wire [`SSRP_ADDR_W-1:0] addr_i,
   input wire pll_bypass_n_i,
   // fetch request to the memory core
   output reg fetch_req_o,
   output reg [`SSRP_ADDR_W-1:0] fetch_addr_o,
   // burst returned by the memory core
   input wire burst_valid_i,
   output wire burst_ready_o,
   input wire [`SSRP_BURST_W-1:0] burst_data_i,
   // read data pins
   output reg [`SSRP_Q_W-1:0] q_o,
   output reg q_oe_o,
   output reg read_valid_flag_o,
   // echo clock pair
   output reg echo_timing_out_o,
   output reg echo_timing_out_n_o
);

   // reset release
   // the pin reset stops the design at once; its release is retimed so no flop leaves reset early

   reg rst_meta_reg; // first reset stage
   reg rst_sync_reg; // released reset used by the design
   wire rst_n; // synchronised active-low reset

   // assert at once, release through two flops
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign rst_n = rst_sync_reg;

   // pin sampling
   // clocks, select, bypass and address are all asynchronous here, so each passes two flops

   wire [3:0] pins_s; // synchronised pins: k, k_n, select_n, bypass_n
   wire k_s; // primary clock level
   wire kn_s; // inverted clock level
   wire sel_n_s; // select level, active low
   wire byp_n_s; // bypass level, active low
   wire [`SSRP_ADDR_W-1:0] addr_s; // synchronised address

   ssrp_sync2 #(
      .W(4)
   ) u_pin_sync (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .d_i({k_i, k_n_i, read_port_select_n_i, pll_bypass_n_i}),
      .q_o(pins_s)
   );

   ssrp_sync2 #(
      .W(`SSRP_ADDR_W)
   ) u_addr_sync (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .d_i(addr_i),
      .q_o(addr_s)
   );

   assign k_s = pins_s[3];
   assign kn_s = pins_s[2];
   assign sel_n_s = pins_s[1];
   assign byp_n_s = pins_s[0];

   // edge finding on the input clock pair
   // edges come from the synchronised levels, so they lag the pins by two or three cycles

   reg k_d_reg; // primary clock one cycle back
   reg kn_d_reg; // inverted clock one cycle back
   wire k_rise; // primary clock rising edge seen
   wire kn_rise; // inverted clock rising edge seen
   wire half_edge; // any launch edge

   // delayed copies taken from the synchronised levels only
   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         k_d_reg <= 1'b0;
         kn_d_reg <= 1'b0;
      end
      else
      begin
         k_d_reg <= k_s;
         kn_d_reg <= kn_s;
      end
   end

   assign k_rise = k_s & ~k_d_reg;
   assign kn_rise = kn_s & ~kn_d_reg;
   assign half_edge = k_rise | kn_rise;

   // request capture
   // a read is taken only on a primary edge, and never on two primary edges in a row

   reg last_acc_reg; // a read was taken at the previous primary edge
   wire accept; // read taken at this primary edge
   wire [2:0] slot; // launch slot for the current latency mode

   // select sampled low on a primary edge starts a read, unless the last edge did
   assign accept = k_rise & ~sel_n_s & ~last_acc_reg;

   // bypass low picks the one cycle legacy timing, high the pll timing
   assign slot = byp_n_s ? `SSRP_SLOT_PLL : `SSRP_SLOT_BYP;

   // remember whether a read was taken, updated on primary edges only
   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         last_acc_reg <= 1'b0;
      else if (k_rise)
         last_acc_reg <= accept;
   end

   // fetch request to the core, one cycle pulse with the address
   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fetch_req_o <= 1'b0;
         fetch_addr_o <= {`SSRP_ADDR_W{1'b0}};
      end
      else
      begin
         fetch_req_o <= accept;
         if (accept)
            fetch_addr_o <= addr_s;
      end
   end

   // burst buffer between core and pins
   // two entries let the core hand a burst back early without waiting for the pins

   wire buf_valid; // a whole burst is waiting
   wire [`SSRP_BURST_W-1:0] buf_data; // head burst
   wire buf_pop; // burst taken for launch

   ssrp_fifo2 #(
      .W(`SSRP_BURST_W)
   ) u_burst_buf (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .in_valid_i(burst_valid_i),
      .in_ready_o(burst_ready_o),
      .in_data_i(burst_data_i),
      .out_ready_i(buf_pop),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data)
   );

   // launch line: counts half edges from the request to the first beat
   // a one-hot bit walks down once per half edge; the slot it starts in sets the latency

   reg [`SSRP_LAUNCH_W-1:0] launch_reg; // one bit per pending burst start
   reg [`SSRP_LAUNCH_W-1:0] launch_next; // next launch line
   wire launch; // first beat due at this half edge
   wire start; // first beat really launched

   assign launch = half_edge & launch_reg[0];
   // a burst whose data never arrived is dropped rather than sent as junk
   assign start = launch & buf_valid;
   assign buf_pop = start;

   // shift once per half edge, drop a new request in at its latency slot
   always @*
   begin
      launch_next = launch_reg;
      if (half_edge)
         launch_next = launch_reg >> 1;
      if (accept)
         launch_next = launch_next | ({{(`SSRP_LAUNCH_W-1){1'b0}}, 1'b1} << slot);
   end

   // hold the launch line
   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         launch_reg <= {`SSRP_LAUNCH_W{1'b0}};
      else
         launch_reg <= launch_next;
   end

   // beat engine: four words, one per half edge, lowest word first
   // the burst is held whole and shifted down, so no word index is needed

   reg [`SSRP_BURST_W-1:0] words_reg; // words still to be sent
   reg [2:0] left_reg; // beats still to be sent after the current one
   wire more; // a burst is in progress

   // a pending burst runs to its end whatever select does now
   assign more = (left_reg != 3'h0);

   // load a new burst or step the running one
   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         words_reg <= {`SSRP_BURST_W{1'b0}};
         left_reg <= 3'h0;
      end
      else if (start)
      begin
         words_reg <= buf_data >> `SSRP_Q_W;
         left_reg <= `SSRP_BEATS_AFTER_FIRST;
      end
      else if (half_edge & more)
      begin
         words_reg <= words_reg >> `SSRP_Q_W;
         left_reg <= left_reg - 3'h1;
      end
   end

   // output pins: data, drive enable, valid flag
   // a late pin change here would break the alignment the host relies on

   // every pin changes only on a half edge, so all stay aligned with the echo clocks
   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q_o <= {`SSRP_Q_W{1'b0}};
         q_oe_o <= 1'b0;
         read_valid_flag_o <= 1'b0;
      end
      else if (start)
      begin
         // first word of a new burst
         q_o <= buf_data[`SSRP_Q_W-1:0];
         q_oe_o <= 1'b1;
         read_valid_flag_o <= 1'b1;
      end
      else if (half_edge & more)
      begin
         // next word of the running burst
         q_o <= words_reg[`SSRP_Q_W-1:0];
         q_oe_o <= 1'b1;
         read_valid_flag_o <= 1'b1;
      end
      else if (half_edge)
      begin
         // no beat here: flag drops at once
         read_valid_flag_o <= 1'b0;
         // release the pins only on an inverted clock edge
         if (kn_rise)
            q_oe_o <= 1'b0;
      end
   end

   // echo clocks
   // one flop of delay keeps the echo edges in step with the data launch

   // copies of the synchronised pair, running whether or not a read is on;
   // the host is expected to capture data and flag against these
   always @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         echo_timing_out_o <= 1'b0;
         echo_timing_out_n_o <= 1'b0;
      end
      else
      begin
         echo_timing_out_o <= k_s;
         echo_timing_out_n_o <= kn_s;
      end
   end

endmodule // ssrp_read_port

// ==== ssrp_consts.vh ====
// constants for the synchronous sram read port
`ifndef SSRP_CONSTS_VH
`define SSRP_CONSTS_VH

// data word width of one beat on the output pins (narrow part; wide part uses 36)
`define SSRP_Q_W 18
// words per read burst
`define SSRP_BURST_LEN 4
// bits of one whole burst held in the buffer
`define SSRP_BURST_W 72
// read address width
`define SSRP_ADDR_W 18
// beats still to go after the first one of a burst
`define SSRP_BEATS_AFTER_FIRST 3'h3
// slot of the launch line for 2.5 cycle latency (five half edges)
`define SSRP_SLOT_PLL 3'h4
// slot of the launch line for 1 cycle latency (two half edges)
`define SSRP_SLOT_BYP 3'h1
// length of the launch line
`define SSRP_LAUNCH_W 5
// system clock period in ns
`define SSRP_SYS_CLK_NS 10
// bypass mode upper clock rate in mhz, kept for the bench
`define SSRP_BYPASS_MAX_MHZ 167

`endif

// ==== ssrp_sync2.v ====
// two flip-flop synchroniser for pin inputs
module ssrp_sync2 #(
   parameter W = 1
) (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // asynchronous level in, synchronised level out
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);

   reg [W-1:0] meta_reg; // first stage, read only by the second
   reg [W-1:0] sync_reg; // second stage, safe to use

   // plain two stage capture
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end
      else
      begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;

endmodule // ssrp_sync2

// ==== ssrp_fifo2.v ====
// two-entry buffer with valid and ready on both sides
module ssrp_fifo2 #(
   parameter W = 72
) (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // filling side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   // draining side
   input wire out_ready_i,
   output wire out_valid_o,
   output wire [W-1:0] out_data_o
);

   reg [W-1:0] mem_reg [0:1]; // the two entries
   reg wr_ptr_reg; // next entry to fill
   reg rd_ptr_reg; // next entry to drain
   reg [1:0] count_reg; // entries held
   reg in_ready_reg; // not full, kept as a flop
   reg out_valid_reg; // not empty, kept as a flop
   wire push; // word accepted
   wire pop; // word taken
   reg [1:0] count_next; // count after this edge

   assign push = in_valid_i & in_ready_reg;
   assign pop = out_ready_i & out_valid_reg;

   // next occupancy
   always @*
   begin
      count_next = count_reg;
      if (push & !pop)
         count_next = count_reg + 2'h1;
      else if (pop & !push)
         count_next = count_reg - 2'h1;
   end

   // pointers, count and flags
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
         in_ready_reg <= 1'b0;
         out_valid_reg <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= ~wr_ptr_reg;
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_next;
         in_ready_reg <= (count_next != 2'h2);
         out_valid_reg <= (count_next != 2'h0);
      end
   end

   // storage needs no reset
   always @(posedge clk_i)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data_i;
   end

   assign in_ready_o = in_ready_reg;
   assign out_valid_o = out_valid_reg;
   assign out_data_o = mem_reg[rd_ptr_reg];

endmodule // ssrp_fifo2

// ==== ssrp_read_port_props.sv ====
// assertions on the read port pins
`include "ssrp_consts.vh"
module ssrp_rp_props (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // watched pins
   input wire logic pll_bypass_n_i,
   input wire logic fetch_req_o,
   input wire logic [`SSRP_Q_W-1:0] q_o,
   input wire logic q_oe_o,
   input wire logic read_valid_flag_o,
   input wire logic echo_timing_out_o,
   input wire logic echo_timing_out_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] gap_cnt; // cycles since last fetch, saturating
   logic [4:0] still_cnt; // cycles since an echo pin last moved
   logic [3:0] beat_cnt; // half edges seen while valid
   logic echo_d;
   logic echo_n_d;
   wire echo_mv = (echo_timing_out_o != echo_d) || (echo_timing_out_n_o != echo_n_d);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // helper counters
   always @(posedge sys_clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         gap_cnt <= 6'h3f;
         still_cnt <= 5'h00;
         beat_cnt <= 4'h0;
         echo_d <= 1'b0;
         echo_n_d <= 1'b0;
      end
      else
      begin
         echo_d <= echo_timing_out_o;
         echo_n_d <= echo_timing_out_n_o;
         gap_cnt <= fetch_req_o ? 6'h00 : gap_cnt + {5'h00, gap_cnt != 6'h3f};
         still_cnt <= echo_mv ? 5'h00 : still_cnt + {4'h0, still_cnt != 5'h1f};
         beat_cnt <= !read_valid_flag_o ? 4'h0 : beat_cnt + {3'h0, echo_mv};
      end
   AST_FETCH_SPACING: assert property (fetch_req_o |-> gap_cnt >= 6'h18)
      else $error("fetch on back to back primary rises");
   AST_ECHO_FREE: assert property (still_cnt < 5'h10)
      else $error("echo clocks stopped");
   AST_Q_ON_HALF: assert property ($changed(q_o) |-> echo_mv)
      else $error("data moved off a half edge");
   AST_VALID_ALIGN: assert property ($changed(read_valid_flag_o) |-> echo_mv)
      else $error("valid flag not aligned with echo");
   AST_VALID_DRIVES: assert property (read_valid_flag_o |-> q_oe_o)
      else $error("valid without driven data");
   AST_FOUR_BEATS: assert property ($fell(read_valid_flag_o) |-> beat_cnt[1:0] == 2'h0 && beat_cnt != 4'h0)
      else $error("burst not a multiple of four beats");
   AST_OE_OFF: assert property ($fell(q_oe_o) |-> $rose(echo_timing_out_n_o))
      else $error("tristate not on inverted clock rise");
   AST_OE_ON: assert property ($rose(q_oe_o) |-> $rose(read_valid_flag_o))
      else $error("driver on without a burst");
   AST_PLL_LAT: assert property (fetch_req_o && pll_bypass_n_i |-> ##[39:41] read_valid_flag_o)
      else $error("pll mode latency wrong");
   AST_BYP_LAT: assert property (fetch_req_o && !pll_bypass_n_i |-> ##[15:17] read_valid_flag_o)
      else $error("bypass mode latency wrong");
   C_PLL: cover property (fetch_req_o && pll_bypass_n_i);
   C_BYP: cover property (fetch_req_o && !pll_bypass_n_i);
   C_PIPE: cover property ($fell(read_valid_flag_o) && beat_cnt == 4'h8);
endmodule // ssrp_rp_props

bind ssrp_read_port ssrp_rp_props u_props (
   .sys_clk_i(sys_clk_i),
   .rst_n_i(rst_n_i),
   .pll_bypass_n_i(pll_bypass_n_i),
   .fetch_req_o(fetch_req_o),
   .q_o(q_o),
   .q_oe_o(q_oe_o),
   .read_valid_flag_o(read_valid_flag_o),
   .echo_timing_out_o(echo_timing_out_o),
   .echo_timing_out_n_o(echo_timing_out_n_o)
);

// ==== ssrp_host_model.sv ====
// host controller model: input clocks, select, address, capture
module ssrp_host_model (
   // system clock
   input wire logic sys_clk_i,
   // device outputs
   input wire logic [17:0] q_o,
   input wire logic read_valid_flag_o,
   input wire logic echo_timing_out_o,
   input wire logic echo_timing_out_n_o,
   // host outputs
   output logic k_o,
   output logic k_n_o,
   output logic sel_n_o,
   output logic [17:0] addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] got[$]; // captured words
   logic ep = 1'b0;
   logic enp = 1'b0;
   // 160 ns input clock, far below the bypass ceiling
   initial
   begin
      k_o = 1'b0;
      sel_n_o = 1'b1;
      addr_o = 18'h00000;
      #3;
      forever #80 k_o = ~k_o;
   end
   assign k_n_o = ~k_o;
   // select low across n primary rises, changed mid period
   task req(input logic [17:0] a, input int n);
      @(posedge k_n_o);
      @(posedge sys_clk_i);
      #1 sel_n_o = 1'b0;
      addr_o = a;
      repeat (n) @(posedge k_n_o);
      @(posedge sys_clk_i);
      #1 sel_n_o = 1'b1;
      addr_o = ~a;
   endtask
   // words taken on echo edges, not on own clock
   always @(posedge sys_clk_i)
   begin
      if (read_valid_flag_o && (echo_timing_out_o != ep || echo_timing_out_n_o != enp))
         got.push_back(q_o);
      ep <= echo_timing_out_o;
      enp <= echo_timing_out_n_o;
   end
endmodule // ssrp_host_model

// ==== test_sync_sram_read_port.sv ====
// self-checking bench for the read port
module test_sync_sram_read_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i, rst_n_i, k_i, k_n_i, sel_n, pll_bypass_n_i, burst_valid_i, v_d;
   logic fetch_req_o, burst_ready_o, q_oe_o, read_valid_flag_o, eo, eo_n;
   logic [17:0] addr_i, fetch_addr_o, q_o;
   logic [71:0] burst_data_i;
   logic hold = 1'b0; // core model stalls fetches
   logic [71:0] cq[$]; // bursts offered by the core
   logic [17:0] exp_q[$]; // expected words
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int t_f = 0;
   int t_v = 0;
   int n_fetch = 0;
   ssrp_read_port u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .k_i(k_i), .k_n_i(k_n_i),
      .read_port_select_n_i(sel_n), .addr_i(addr_i), .pll_bypass_n_i(pll_bypass_n_i),
      .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o), .burst_valid_i(burst_valid_i),
      .burst_ready_o(burst_ready_o), .burst_data_i(burst_data_i), .q_o(q_o), .q_oe_o(q_oe_o),
      .read_valid_flag_o(read_valid_flag_o), .echo_timing_out_o(eo), .echo_timing_out_n_o(eo_n));
   ssrp_host_model u_host (.sys_clk_i(sys_clk_i), .q_o(q_o), .read_valid_flag_o(read_valid_flag_o),
      .echo_timing_out_o(eo), .echo_timing_out_n_o(eo_n), .k_o(k_i), .k_n_o(k_n_i),
      .sel_n_o(sel_n), .addr_o(addr_i));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [71:0] mk(input logic [17:0] a);
      return {a + 18'h3, a + 18'h2, a + 18'h1, a};
   endfunction
   // core model behind the two-entry buffer
   always @(posedge sys_clk_i)
   begin
      if (burst_valid_i === 1'b1 && burst_ready_o === 1'b1)
         void'(cq.pop_front());
      if (fetch_req_o === 1'b1 && !hold)
         cq.push_back(mk(fetch_addr_o));
      #1 burst_valid_i = (cq.size() != 0);
      burst_data_i = burst_valid_i ? cq[0] : ~burst_data_i;
   end
   // cycle count, fetch and first-beat times, hang limit
   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (fetch_req_o === 1'b1)
      begin
         t_f <= cyc;
         n_fetch <= n_fetch + 1;
      end
      if (read_valid_flag_o === 1'b1 && v_d !== 1'b1)
         t_v <= cyc;
      v_d <= read_valid_flag_o;
      if (cyc == 20000)
      begin
         n_errors++;
         complete_run();
      end
   end
   task chk(input bit ok, input string m);
      checks_done++;
      if (!ok)
      begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task push_exp(input logic [17:0] a);
      for (int i = 0; i < 4; i++)
         exp_q.push_back(a + i[17:0]);
   endtask
   // let bursts finish, then compare captured words
   task cmp_words;
      repeat (120) @(posedge sys_clk_i);
      chk(u_host.got.size() == exp_q.size(), "word count");
      foreach (exp_q[i])
         if (i < u_host.got.size())
            chk(u_host.got[i] === exp_q[i], "word value");
      chk(q_oe_o === 1'b0, "driver still on after deselect");
      u_host.got.delete();
      exp_q.delete();
   endtask
   task t_reset;
      chk(q_oe_o === 1'b0 && read_valid_flag_o === 1'b0, "pins active after reset");
      chk(burst_ready_o === 1'b1, "buffer not ready after reset");
   endtask
   // echo pair must toggle every half period of the input clock, complementary
   task t_echo;
      int n;
      logic e0;
      n = 0;
      repeat (32)
      begin
         e0 = eo;
         @(posedge sys_clk_i);
         n += (eo !== e0);
      end
      chk(n == 4 && eo_n === ~eo, "echo clocks not free running");
   endtask
   task t_pll;
      u_host.req(18'h01234, 1);
      push_exp(18'h01234);
      cmp_words();
      chk(fetch_addr_o === 18'h01234, "address not taken");
      chk(t_v - t_f >= 39 && t_v - t_f <= 41, "pll latency");
   endtask
   task t_b2b;
      int n0;
      n0 = n_fetch;
      u_host.req(18'h02000, 2);
      push_exp(18'h02000);
      cmp_words();
      chk(n_fetch - n0 == 1, "second back to back read taken");
   endtask
   task t_pipe;
      u_host.req(18'h3fff0, 1);
      u_host.req(18'h00100, 1);
      push_exp(18'h3fff0);
      push_exp(18'h00100);
      cmp_words();
   endtask
   task t_bypass;
      #1 pll_bypass_n_i = 1'b0;
      repeat (10) @(posedge sys_clk_i);
      u_host.req(18'h0abcd, 1);
      push_exp(18'h0abcd);
      cmp_words();
      chk(t_v - t_f >= 15 && t_v - t_f <= 17, "bypass latency");
      #1 pll_bypass_n_i = 1'b1;
      repeat (10) @(posedge sys_clk_i);
   endtask
   // core stalls: buffer fills and refuses, reads drain it
   task t_fill;
      hold = 1'b1;
      cq.push_back(mk(18'h00a00));
      cq.push_back(mk(18'h00b00));
      cq.push_back(mk(18'h00c00));
      repeat (10) @(posedge sys_clk_i);
      chk(burst_ready_o === 1'b0 && cq.size() == 1, "buffer took a third burst");
      u_host.req(18'h00a00, 1);
      u_host.req(18'h00b00, 1);
      u_host.req(18'h00c00, 1);
      push_exp(18'h00a00);
      push_exp(18'h00b00);
      push_exp(18'h00c00);
      cmp_words();
      chk(burst_ready_o === 1'b1 && cq.size() == 0, "buffer not drained");
      hold = 1'b0;
   endtask
   task complete_run;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      rst_n_i = 1'b0;
      pll_bypass_n_i = 1'b1;
      burst_valid_i = 1'b0;
      burst_data_i = 72'h0;
      repeat (8) @(posedge sys_clk_i);
      #1 rst_n_i = 1'b1;
      repeat (10) @(posedge sys_clk_i);
      t_reset();
      t_echo();
      t_pll();
      t_b2b();
      t_pipe();
      t_bypass();
      t_fill();
      complete_run();
   end
endmodule // test_sync_sram_read_port
